/* File: rtl/qms_mode_switch.sv */
// Purpose: command-mode tracking (single-line vs four-line) of a serial flash command port
// Assumes: csN, sclk and io come from pins and are resynchronised to mclk
// Notes: only the opcode byte is decoded here; command bodies belong to other logic
`default_nettype none
// Function
// - quad-enable set then 38H enters four-line mode
// - 38H ignored while quad-enable is zero
// - entering four-line keeps latch, suspend, wrap length
// - FFH returns device to single-line command mode
// - leaving four-line keeps latch, suspend, wrap length
// - opcode 5AH starts discoverable parameter table read
// - delivered array reads all ones, FFH
// - status resets to 00H, single-line mode
// - enable-reset, reset pair works in both modes
module qms_mode_switch
	import qms_pkg::*;
#(
	parameter int POWER_UP_CYC = POWER_UP_WAIT_CYC
)
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       csN,
	input  wire logic       sclk,
	input  wire logic [3:0] ioIn,
	input  wire logic       statusWrite,
	input  wire logic [7:0] statusData,
	input  wire logic       volWrite,
	input  wire qms_vol_s   volData,
	output qms_mode_e       commandMode,
	output logic [7:0]      statusReg,
	output logic            quadEnableBit,
	output qms_vol_s        volState,
	output qms_cmd_s        opcodeOut,
	output logic            paramReadStart,
	output logic            softResetPulse,
	output logic            deviceReady,
	output logic [7:0]      eraseFill
);

	logic [1:0] csSync;
	logic [1:0] sclkSync;
	logic [3:0] ioSync1;
	logic [3:0] ioSync2;
	logic       sclkLast;
	logic       csLast;
	logic       sclkRise;
	logic       csRise;
	logic       csFall;
	logic       csLow;

	// first stages feed only the second stages
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			csSync   <= 2'h3;
			sclkSync <= 2'h0;
			ioSync1  <= 4'h0;
			ioSync2  <= 4'h0;
			sclkLast <= 1'b0;
			csLast   <= 1'b1;
		end
		else
		begin
			csSync   <= {csSync[0], csN};
			sclkSync <= {sclkSync[0], sclk};
			ioSync1  <= ioIn;
			ioSync2  <= ioSync1;
			sclkLast <= sclkSync[1];
			csLast   <= csSync[1];
		end
	end

	assign csLow    = !csSync[1];
	assign sclkRise = sclkSync[1] && !sclkLast && csLow;
	assign csRise   = csSync[1] && !csLast;
	assign csFall   = !csSync[1] && csLast;

	// power-up hold-off; commands before it are not trusted
	logic [$clog2(POWER_UP_CYC + 1) - 1:0] upCount_reg;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			upCount_reg <= '0;
		else if (upCount_reg != POWER_UP_CYC[$clog2(POWER_UP_CYC + 1) - 1:0])
			upCount_reg <= upCount_reg + 1'b1;
	end

	assign deviceReady = (upCount_reg == POWER_UP_CYC[$clog2(POWER_UP_CYC + 1) - 1:0]);

	// opcode shifter: one bit per edge in single-line, a nibble in four-line
	logic [7:0] shift_reg;
	logic [3:0] bitCount_reg;
	logic       frameValid_reg;
	logic       opDone;

	assign opDone = (bitCount_reg == BITS_PER_OP);

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_reg      <= 8'h00;
			bitCount_reg   <= 4'h0;
			frameValid_reg <= 1'b0;
		end
		else if (csFall)
		begin
			shift_reg      <= 8'h00;
			bitCount_reg   <= 4'h0;
			frameValid_reg <= deviceReady;
		end
		else if (sclkRise && frameValid_reg)
		begin
			if (commandMode == MODE_FOUR)
			begin
				// past eight bits the count parks at nine, so no second opcode can form
				if (bitCount_reg < BITS_PER_OP)
				begin
					shift_reg    <= {shift_reg[3:0], ioSync2};
					bitCount_reg <= bitCount_reg + 4'h4;
				end
				else
					bitCount_reg <= 4'h9;
			end
			else
			begin
				if (bitCount_reg < BITS_PER_OP)
				begin
					shift_reg    <= {shift_reg[6:0], ioSync2[0]};
					bitCount_reg <= bitCount_reg + 4'h1;
				end
				else
					bitCount_reg <= 4'h9;
			end
		end
	end

	// opcode is announced once, one mclk cycle after its eighth bit lands in shift_reg
	logic opJustDone_reg;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			opJustDone_reg <= 1'b0;
		else
			opJustDone_reg <= sclkRise && frameValid_reg && (bitCount_reg == BITS_PER_OP - 4'h1 ||
				(commandMode == MODE_FOUR && bitCount_reg == BITS_PER_OP - 4'h4));
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			opcodeOut <= '0;
		else
		begin
			opcodeOut.valid    <= opJustDone_reg;
			opcodeOut.code     <= shift_reg;
			opcodeOut.fourLine <= (commandMode == MODE_FOUR);
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			paramReadStart <= 1'b0;
		else
			paramReadStart <= opJustDone_reg && shift_reg == OP_PARAM_READ;
	end

	// a frame counts only if exactly eight bits arrived before chip select rose
	logic exactOp;
	assign exactOp = csRise && frameValid_reg && opDone;

	// reset arming: enable-reset must be the frame right before reset
	logic resetArmed_reg;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			resetArmed_reg <= 1'b0;
		else if (csRise && frameValid_reg)
			resetArmed_reg <= exactOp && shift_reg == OP_RESET_EN;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			softResetPulse <= 1'b0;
		else
			softResetPulse <= exactOp && resetArmed_reg && shift_reg == OP_RESET;
	end

	// mode register; an opcode switch lands at chip-select rise, a soft reset one mclk cycle later
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			commandMode <= MODE_SPI;
		else if (softResetPulse)
			commandMode <= MODE_SPI;
		else if (exactOp)
		begin
			unique case (commandMode)
				MODE_SPI:
					if (shift_reg == OP_ENTER_FOUR && quadEnableBit)
						commandMode <= MODE_FOUR;
				MODE_FOUR:
					if (shift_reg == OP_EXIT_FOUR)
						commandMode <= MODE_SPI;
			endcase
		end
	end

	// status register: written by the write-status logic, cleared only by rst_n, not by software reset
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			statusReg <= STATUS_RESET;
		else if (statusWrite)
			statusReg <= statusData;
	end

	assign quadEnableBit = statusReg[QE_POS];

	// volatile state is deliberately not touched by mode switches, only by its owner or reset
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			volState <= VOL_RESET;
		else if (softResetPulse)
			volState <= VOL_RESET;
		else if (volWrite)
			volState <= volData;
	end

	// fill value used when the array is initialised in the delivered state
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			eraseFill <= ERASED_BYTE;
		else
			eraseFill <= ERASED_BYTE;
	end

endmodule
`default_nettype wire

/* File: rtl/qms_pkg.sv */
// Purpose: shared constants and types of the command mode switch
// Assumes: 125 MHz mclk
// Notes: opcodes and delivered-state values of the command interface
`default_nettype none
package qms_pkg;
	localparam logic [7:0] OP_ENTER_FOUR  = 8'h38;
	localparam logic [7:0] OP_EXIT_FOUR   = 8'hff;
	localparam logic [7:0] OP_PARAM_READ  = 8'h5a;
	localparam logic [7:0] OP_RESET_EN    = 8'h66;
	localparam logic [7:0] OP_RESET       = 8'h99;
	localparam logic [7:0] STATUS_RESET   = 8'h00;
	localparam logic [7:0] ERASED_BYTE    = 8'hff;
	localparam int         QE_POS         = 1;
	localparam logic [3:0] BITS_PER_OP    = 4'h8;
	localparam int         CLK_PERIOD_NS  = 8;
	localparam int         POWER_UP_WAIT_MS = 1;
	// least time, rounded up to whole cycles
	localparam int         POWER_UP_WAIT_CYC = (POWER_UP_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic {MODE_SPI, MODE_FOUR} qms_mode_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic       fourLine;
	} qms_cmd_s;

	typedef struct packed {
		logic       writeLatch;
		logic       suspended;
		logic [2:0] wrapLen;
	} qms_vol_s;

	localparam qms_vol_s VOL_RESET = '{writeLatch: 1'b0, suspended: 1'b0, wrapLen: 3'h0};
endpackage
`default_nettype wire

/* File: test/qms_host_model.sv */
// Purpose: host driving the command pins
// Assumes: 125 ns serial clock
// Notes: io inverted between frames
`default_nettype none
module qms_host_model
(
	output logic	csN,
	output logic	sclk,
	output logic [3:0]	ioIn
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {csN, sclk, ioIn} = 6'h20;
	// n edges short of a whole opcode give a frame the device must refuse
	task automatic send(input logic [7:0] op, input logic four, input int n);
		// odd offset keeps every pin edge away from an mclk edge
		#0.3;
		csN = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			ioIn = four ? op[7:4] : {~ioIn[3:1], op[7]};
			op = four ? {op[3:0], 4'h0} : {op[6:0], 1'b0};
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		#62.5 csN = 1'b1;
		ioIn = ~ioIn;
		#250;
	endtask
endmodule
`default_nettype wire

/* File: test/qms_monitor.sv */
// Purpose: port checks of the mode switch
// Assumes: bound into qms_mode_switch
// Notes: link pins are judged by the bench
`default_nettype none
module qms_monitor
	import qms_pkg::*;
(
	input wire logic	mclk,
	input wire logic	rst_n,
	input wire logic	statusWrite,
	input wire logic [7:0]	statusData,
	input wire logic	volWrite,
	input wire qms_mode_e	commandMode,
	input wire logic [7:0]	statusReg,
	input wire logic	quadEnableBit,
	input wire qms_vol_s	volState,
	input wire qms_cmd_s	opcodeOut,
	input wire logic	paramReadStart,
	input wire logic	softResetPulse
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_qe_bit: assert property (quadEnableBit == statusReg[QE_POS]) else $error("qe");
	a_enter_needs_qe: assert property ($rose(commandMode) |-> $past(quadEnableBit)) else $error("no qe");
	a_vol_kept: assert property ($changed(commandMode) && !$past(volWrite) && !$past(softResetPulse)
		|-> $stable(volState)) else $error("vol");
	a_status_load: assert property (statusWrite |=> statusReg == $past(statusData)) else $error("status");
	a_param_start: assert property (opcodeOut.valid && opcodeOut.code == OP_PARAM_READ
		|-> ##[0:1] paramReadStart) else $error("param");
	a_echo_single: assert property (opcodeOut.valid |=> !opcodeOut.valid) else $error("echo");
	a_echo_mode: assert property (opcodeOut.valid |-> opcodeOut.fourLine == commandMode) else $error("line");
	a_reset_spi: assert property (softResetPulse |=> commandMode == MODE_SPI && volState == VOL_RESET)
		else $error("reset");
	c_four: cover property (commandMode == MODE_FOUR);
	c_param: cover property (paramReadStart);
	c_reset: cover property (softResetPulse);
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: self-checking bench of the mode switch
// Assumes: power-up wait cut to 16 cycles
// Notes: opcode echoes matched from a queue
`default_nettype none
module tb_top
	import qms_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic	mclk = 1'b0, rst_n, csN, sclk, statusWrite, volWrite, deviceReady;
	logic [3:0]	ioIn;
	logic [7:0]	statusData, statusReg, eraseFill;
	logic [31:0]	lfsr = 32'h00015fc5;
	qms_vol_s	volData, volState;
	qms_mode_e	commandMode;
	qms_cmd_s	opcodeOut;
	logic [8:0]	expQ[$];
	int	n_fail = 0, n_tests = 0;
	qms_mode_switch #(.POWER_UP_CYC(16)) uut (.mclk, .rst_n, .csN, .sclk, .ioIn, .statusWrite, .statusData,
		.volWrite, .volData, .commandMode, .statusReg, .quadEnableBit(), .volState, .opcodeOut,
		.paramReadStart(), .softResetPulse(), .deviceReady, .eraseFill);
	qms_host_model host (.csN, .sclk, .ioIn);
	initial
		forever #4 mclk = ~mclk;
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input logic ok, input string m);
		n_tests++;
		n_fail += int'(ok !== 1'b1);
		if (ok !== 1'b1)
			$display("mismatch %0t %s", $time, m);
	endtask
	task automatic report_and_stop();
		if (n_fail == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic fr(input logic [7:0] op, input logic f, input int n, input qms_mode_e m);
		if (n >= (f ? 2 : 8))
			expQ.push_back({op, f});
		host.send(op, f, n);
		@(posedge mclk) #1;
		chk(commandMode === m, "mode");
	endtask
	// random volatile state, so a loss across a switch cannot hide behind zeros
	task automatic ld();
		lfsr = nx(lfsr);
		@(posedge mclk) #1;
		{statusWrite, volWrite, statusData, volData} = {2'h3, lfsr[7:0] | (8'h01 << QE_POS), lfsr[12:8]};
		@(posedge mclk) #1;
		{statusWrite, volWrite} = 2'h0;
		chk(statusReg === statusData && volState === volData, "load");
	endtask
	always @(posedge mclk)
		if (opcodeOut.valid === 1'b1)
			chk(expQ.size() > 0 && expQ.pop_front() === {opcodeOut.code, opcodeOut.fourLine}, "echo");
	initial
	begin
		{rst_n, statusWrite, volWrite, statusData, volData} = '0;
		repeat (3) @(posedge mclk);
		#1 rst_n = 1'b1;
		chk(statusReg === STATUS_RESET && eraseFill === ERASED_BYTE, "reset");
		for (int i = 0; i < 24 && deviceReady !== 1'b1; i++)
			@(posedge mclk) #1;
		chk(deviceReady === 1'b1, "ready");
		if (deviceReady !== 1'b1)
			report_and_stop();
		fr(OP_ENTER_FOUR, 1'b0, 8, MODE_SPI);
		ld();
		fr(OP_ENTER_FOUR, 1'b0, 7, MODE_SPI);
		fr(OP_ENTER_FOUR, 1'b0, 8, MODE_FOUR);
		chk(volState === volData, "kept");
		fr(OP_ENTER_FOUR, 1'b1, 2, MODE_FOUR);
		fr(OP_PARAM_READ, 1'b1, 2, MODE_FOUR);
		fr(OP_EXIT_FOUR, 1'b1, 2, MODE_SPI);
		chk(volState === volData, "kept");
		fr(OP_EXIT_FOUR, 1'b0, 8, MODE_SPI);
		// overlong frame: one echo, no switch, no second opcode
		fr(OP_ENTER_FOUR, 1'b0, 24, MODE_SPI);
		for (int f = 0; f < 2; f++)
		begin
			ld();
			if (f)
				fr(OP_ENTER_FOUR, 1'b0, 8, MODE_FOUR);
			fr(OP_RESET_EN, f[0], f ? 2 : 8, qms_mode_e'(f));
			fr(OP_RESET, f[0], f ? 2 : 8, MODE_SPI);
			chk(volState === VOL_RESET, "vol");
		end
		fr(OP_ENTER_FOUR, 1'b0, 8, MODE_FOUR);
		rst_n = 1'b0;
		@(posedge mclk) #1;
		chk(commandMode === MODE_SPI && statusReg === STATUS_RESET, "rerun");
		rst_n = 1'b1;
		// frame started before the hold-off ends must give no echo
		host.send(OP_PARAM_READ, 1'b0, 8);
		chk(deviceReady === 1'b1, "ready");
		fr(OP_PARAM_READ, 1'b0, 8, MODE_SPI);
		chk(expQ.size() == 0, "count");
		report_and_stop();
	end
endmodule
bind qms_mode_switch qms_monitor mon (.mclk, .rst_n, .statusWrite, .statusData, .volWrite, .commandMode,
	.statusReg, .quadEnableBit, .volState, .opcodeOut, .paramReadStart, .softResetPulse);
`default_nettype wire
